// ===== btsw_health.sv
// health word assembly, phase tracking and packet scheduling
//
// Overview of operation
// - every packet carries the 16-bit health word
// - low byte errors, high byte maskable alerts
// - bit 0 flags a fatal fault
// - bits 1-3: hardware, link, software faults
// - bit 8 set when any enabled alert
// - bit 10 flags missing positioning link
// - bit 12 flags sensor over-range
// - bit 11 flags initialization or high gain
// - each alert type enabled individually
// - optionally bit 11 also follows turn detect
// - turn threshold adjustable, default 10 deg/s
// - filtered yaw over threshold lowers accel gain
// - fixed 100 Hz update rate
// - sixty second high gain start phase
// - periodic packet rates or on request only
// - fetch command returns diagnostic packet
// - angle packet is the default kind
// - magnetic reference switched off for periods
// - restart mode: over-range fatal until quasi-static with over-range cleared
// - no restart: flag over-range, keep running
`timescale 1ns/1ps
module btsw_health #(
  parameter int TICK_CYCLES = btsw_pkg::TICK_CYCLES,
  parameter int INIT_TICKS  = btsw_pkg::INIT_TICKS
) (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic [btsw_pkg::ADDR_W-1:0]  addr,
  input  wire logic [btsw_pkg::DATA_W-1:0]  wdata,
  input  wire logic                         wstrb,
  input  wire logic                         rstrb,
  output logic      [btsw_pkg::DATA_W-1:0]  rdata,
  input  wire logic                         fatal_in,
  input  wire logic                         hw_fault,
  input  wire logic                         link_fault,
  input  wire logic                         sw_fault,
  input  wire logic                         hw_alert_in,
  input  wire logic                         link_absent,
  input  wire logic                         rate_rate_limit_exceeded_flag,
  input  wire logic                         quasi_static,
  input  wire logic [15:0]                  yaw_rate,
  output logic      [15:0]                  health_word,
  output logic                              pkt_stb,
  output btsw_pkg::btsw_pkt_e               pkt_kind,
  output logic      [15:0]                  pkt_health,
  output logic                              high_gain,
  output logic                              accel_gain_low,
  output logic                              mag_ref_on,
  output logic                              update_tick
);
  import btsw_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] thresh;
    logic [15:0] mag_off;
    btsw_phase_e phase;
    logic [15:0] init_cnt;
    logic [5:0]  rate_cnt;
    logic        diag_pend;
    logic        meas_pend;
    logic [15:0] health;
    logic        pkt_stb;
    btsw_pkt_e   pkt_kind;
    logic [15:0] pkt_health;
    logic        high_gain;
    logic        mag_ref_on;
    logic [31:0] rdata;
  } btsw_state_s;

  localparam btsw_state_s RST_S = '{
    ctrl:       CTRL_RST,
    thresh:     THRESH_RST,
    mag_off:    '0,
    phase:      PH_INIT,
    init_cnt:   16'(INIT_TICKS),
    rate_cnt:   '0,
    diag_pend:  1'b0,
    meas_pend:  1'b0,
    health:     '0,
    pkt_stb:    1'b0,
    pkt_kind:   PKT_ANGLE,
    pkt_health: '0,
    high_gain:  1'b1,
    mag_ref_on: 1'b1,
    rdata:      '0
  };

  btsw_state_s s;
  btsw_state_s next_s;
  logic        tick;
  logic        turn_active;

  // ==========================================================================
  // submodules
  btsw_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_div (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .tick    (tick)
  );

  btsw_turn_detect u_turn (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .tick     (tick),
    .yaw_rate (yaw_rate),
    .thresh   (s.thresh),
    .active   (turn_active)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic [15:0] hw;
    logic        restart;
    logic        fatal_now;
    logic        diag_req;
    logic        meas_req;
    logic        periodic;
    logic [2:0]  rate_sel;
    logic [3:0]  alerts;
    hw        = '0;
    alerts    = '0;
    fatal_now = 1'b0;
    restart   = s.ctrl[CT_RESTART];
    rate_sel  = s.ctrl[CT_RATE_LSB +: CT_RATE_W];
    diag_req  = 1'b0;
    meas_req  = 1'b0;
    periodic  = 1'b0;
    next_s    = s;
    next_s.pkt_stb = 1'b0;
    next_s.rdata   = '0;

    // register writes
    if (wstrb) begin
      if (addr == ADR_CTRL) begin
        next_s.ctrl     = wdata & CTRL_MASK;
      end else if (addr == ADR_THRESH) begin
        next_s.thresh = wdata[15:0];
      end else if (addr == ADR_MAGOFF) begin
        next_s.mag_off = wdata[15:0];
      end else if (addr == ADR_CMD) begin
        diag_req = wdata[CMD_DIAG];
        meas_req = wdata[CMD_MEAS];
      end
    end

    // magnetic reference off-period counts down in update ticks
    if (tick && s.mag_off != '0 && !(wstrb && addr == ADR_MAGOFF)) begin
      next_s.mag_off = s.mag_off - 16'h0001;
    end
    next_s.mag_ref_on = next_s.mag_off == '0;

    // algorithm phase
    case (s.phase)
      PH_INIT: begin
        if (restart && rate_rate_limit_exceeded_flag) begin
          next_s.phase = PH_HOLD;
        end else if (tick) begin
          if (s.init_cnt == '0) begin
            next_s.phase = PH_RUN;
          end else begin
            next_s.init_cnt = s.init_cnt - 16'h0001;
          end
        end
      end
      PH_RUN: begin
        if (restart && rate_rate_limit_exceeded_flag) begin
          next_s.phase = PH_HOLD;
        end
      end
      PH_HOLD: begin
        // restart only once all rates settle, so the bias estimate is clean
        if (quasi_static && !rate_rate_limit_exceeded_flag) begin
          next_s.phase    = PH_INIT;
          next_s.init_cnt = 16'(INIT_TICKS);
        end
      end
      default: begin
        next_s.phase = PH_INIT;
      end
    endcase
    next_s.high_gain = next_s.phase == PH_INIT;

    // health word
    fatal_now = fatal_in || s.phase == PH_HOLD
              || (restart && rate_rate_limit_exceeded_flag);
    hw[HB_FATAL] = fatal_now;
    hw[HB_HWF]   = hw_fault;
    hw[HB_LNKF]  = link_fault;
    hw[HB_SWF]   = sw_fault;
    alerts[EN_HW]   = hw_alert_in;
    alerts[EN_LINK] = link_absent;
    alerts[EN_ALGO] = s.high_gain
                    || (s.ctrl[CT_TURN] && turn_active);
    alerts[EN_SENS] = rate_rate_limit_exceeded_flag;
    alerts = alerts & s.ctrl[EN_HW +: 4];
    hw[HB_HWA]  = alerts[EN_HW];
    hw[HB_LNKA] = alerts[EN_LINK];
    hw[HB_ALGA] = alerts[EN_ALGO];
    hw[HB_OVRA] = alerts[EN_SENS];
    hw[HB_ANY]  = |alerts;
    next_s.health = hw;

    // packet scheduling; a request that meets a busy slot stays pending
    if (tick && rate_sel != RATE_REQ) begin
      if (s.rate_cnt + 6'h01 >= btsw_rate_div(rate_sel)) begin
        periodic        = 1'b1;
        next_s.rate_cnt = '0;
      end else begin
        next_s.rate_cnt = s.rate_cnt + 6'h01;
      end
    end
    // a control write restarts the rate count even in an update cycle
    if (wstrb && addr == ADR_CTRL) begin
      next_s.rate_cnt = '0;
    end
    next_s.diag_pend = s.diag_pend || diag_req;
    next_s.meas_pend = s.meas_pend || meas_req;
    if (periodic) begin
      next_s.pkt_stb  = 1'b1;
      next_s.pkt_kind = s.ctrl[CT_KIND] ? PKT_SCALED : PKT_ANGLE;
    end else if (s.diag_pend) begin
      next_s.pkt_stb   = 1'b1;
      next_s.pkt_kind  = PKT_DIAG;
      next_s.diag_pend = diag_req;
    end else if (s.meas_pend) begin
      next_s.pkt_stb   = 1'b1;
      next_s.pkt_kind  = s.ctrl[CT_KIND] ? PKT_SCALED : PKT_ANGLE;
      next_s.meas_pend = meas_req;
    end
    next_s.pkt_health = hw;

    // register reads, data valid in the following cycle only
    if (rstrb) begin
      if (addr == ADR_CTRL) begin
        next_s.rdata = s.ctrl;
      end else if (addr == ADR_THRESH) begin
        next_s.rdata = {16'h0000, s.thresh};
      end else if (addr == ADR_MAGOFF) begin
        next_s.rdata = {16'h0000, s.mag_off};
      end else if (addr == ADR_CMD) begin
        next_s.rdata = {30'h0000_0000, s.meas_pend, s.diag_pend};
      end else if (addr == ADR_STATUS) begin
        next_s.rdata = {12'h000, s.high_gain, turn_active, s.mag_ref_on,
                        s.phase == PH_HOLD, s.health};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata          = s.rdata;
  assign health_word    = s.health;
  assign pkt_stb        = s.pkt_stb;
  assign pkt_kind       = s.pkt_kind;
  assign pkt_health     = s.pkt_health;
  assign high_gain      = s.high_gain;
  assign accel_gain_low = turn_active;
  assign mag_ref_on     = s.mag_ref_on;
  assign update_tick    = tick;

  // ==========================================================================
  // assertions
  sequence s_fetch;
    wstrb && addr == ADR_CMD && wdata[CMD_DIAG];
  endsequence

  sequence s_diag_out;
    pkt_stb && pkt_kind == PKT_DIAG;
  endsequence

  AST_PKT_WORD: assert property (@(posedge sys_clk) disable iff (!nrst)
    pkt_stb |-> pkt_health == health_word)
    else $error("packet health differs from health word");

  AST_FATAL: assert property (@(posedge sys_clk) disable iff (!nrst)
    fatal_in |=> health_word[HB_FATAL])
    else $error("fatal input not reported");

  AST_FAULTS: assert property (@(posedge sys_clk) disable iff (!nrst)
    ##1 health_word[3:1] == $past({sw_fault, link_fault, hw_fault}))
    else $error("fault bits wrong");

  AST_ANY: assert property (@(posedge sys_clk) disable iff (!nrst)
    health_word[HB_ANY] == |health_word[HB_OVRA:HB_HWA])
    else $error("summary alert mismatch");

  AST_LINK: assert property (@(posedge sys_clk) disable iff (!nrst)
    link_absent && s.ctrl[EN_LINK] |=> health_word[HB_LNKA])
    else $error("link alert missing");

  AST_OVR: assert property (@(posedge sys_clk) disable iff (!nrst)
    rate_rate_limit_exceeded_flag && s.ctrl[EN_SENS] |=> health_word[HB_OVRA])
    else $error("over-range alert missing");

  AST_INIT_ALERT: assert property (@(posedge sys_clk) disable iff (!nrst)
    high_gain && s.ctrl[EN_ALGO] |=> health_word[HB_ALGA])
    else $error("init alert missing");

  AST_MASK: assert property (@(posedge sys_clk) disable iff (!nrst)
    !s.ctrl[EN_HW] |=> !health_word[HB_HWA])
    else $error("disabled alert shown");

  AST_TURN_ALERT: assert property (@(posedge sys_clk) disable iff (!nrst)
    turn_active && s.ctrl[CT_TURN] && s.ctrl[EN_ALGO]
      |=> health_word[HB_ALGA])
    else $error("turn alert missing");

  AST_INIT_END: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.phase == PH_INIT && s.init_cnt == '0 && tick
      && !(s.ctrl[CT_RESTART] && rate_rate_limit_exceeded_flag) |=> !high_gain)
    else $error("init phase did not end");

  AST_RATE_100: assert property (@(posedge sys_clk) disable iff (!nrst)
    tick && s.ctrl[CT_RATE_LSB +: CT_RATE_W] == 3'h0 |=> pkt_stb)
    else $error("periodic packet missing");

  AST_FETCH: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_fetch |-> ##[1:3] s_diag_out)
    else $error("diagnostic packet not returned");

  AST_MAG_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    wstrb && addr == ADR_MAGOFF && wdata[15:0] != '0 |=> !mag_ref_on)
    else $error("magnetic reference still on");

  AST_RESTART_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.ctrl[CT_RESTART] && rate_rate_limit_exceeded_flag
      |=> health_word[HB_FATAL] && s.phase == PH_HOLD)
    else $error("over-range fatal hold missing");

  AST_NO_RESTART: assert property (@(posedge sys_clk) disable iff (!nrst)
    !s.ctrl[CT_RESTART] && rate_rate_limit_exceeded_flag && !fatal_in && s.phase != PH_HOLD
      |=> !health_word[HB_FATAL])
    else $error("over-range stopped operation");

  AST_RESERVED: assert property (@(posedge sys_clk) disable iff (!nrst)
    health_word[7:4] == '0 && health_word[15:13] == '0)
    else $error("reserved health bits set");

  AST_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
    rstrb && addr == ADR_THRESH |=> rdata == {16'h0000, $past(s.thresh)})
    else $error("threshold read wrong");

endmodule

// ===== btsw_health_tb.sv
// self-checking testbench for the health word block
`timescale 1ns/1ps
module btsw_health_tb;
  import btsw_pkg::*;
  localparam int TC = 20;
  localparam int IT = 5;
  logic        sys_clk, nrst, wstrb, rstrb;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v, seed, d;
  logic        fatal_in, hw_fault, link_fault, sw_fault, hw_alert_in;
  logic        link_absent, rate_rate_limit_exceeded_flag, quasi_static;
  logic [15:0] yaw_rate, health_word, pkt_health;
  logic        pkt_stb, high_gain, accel_gain_low, mag_ref_on, update_tick;
  logic [3:0]  en, kind_hist;
  btsw_pkt_e   pkt_kind;
  int          failures, checks, pkt_cnt, bad_cnt, n, p0, hits;
  int          rate [7] = '{100, 50, 25, 20, 10, 5, 2};

  btsw_health #(.TICK_CYCLES(TC), .INIT_TICKS(IT)) i_dut (
    .sys_clk, .nrst, .addr, .wdata, .wstrb, .rstrb, .rdata,
    .fatal_in, .hw_fault, .link_fault, .sw_fault, .hw_alert_in,
    .link_absent, .rate_rate_limit_exceeded_flag, .quasi_static, .yaw_rate,
    .health_word, .pkt_stb, .pkt_kind, .pkt_health, .high_gain,
    .accel_gain_low, .mag_ref_on, .update_tick);

  btsw_host_model i_host (
    .sys_clk, .pkt_stb, .pkt_kind, .pkt_health, .health_word,
    .pkt_cnt, .bad_cnt, .kind_hist);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // =========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // reference word from the sampled sources and the alert enables
  function automatic logic [15:0] exp_hw(input logic [6:0] r,
                                         input logic [3:0] e);
    logic [15:0] h;
    h = 16'h0000;
    h[3:0] = r[3:0];
    h[9] = r[4] & e[0];
    h[10] = r[5] & e[1];
    h[12] = r[6] & e[3];
    h[8] = |h[12:9];
    return h;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge sys_clk);
    addr <= a;
    wdata <= dat;
    wstrb <= 1'b1;
    @(posedge sys_clk);
    wstrb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge sys_clk);
    addr <= a;
    rstrb <= 1'b1;
    @(posedge sys_clk);
    rstrb <= 1'b0;
    #1 dat = rdata;
  endtask

  // a bound that runs out ends the run as a failure
  task automatic wait_for(ref logic s, input logic lvl, input int lim,
                          output int k);
    for (k = 1; k <= lim; k++) begin
      @(posedge sys_clk);
      #1;
      if (s === lvl)
        return;
    end
    failures++;
    end_sim();
  endtask

  // =========================================================================
  // main sequence
  initial begin
    {nrst, wstrb, rstrb, fatal_in, hw_fault, link_fault, sw_fault} = '0;
    {hw_alert_in, link_absent, rate_rate_limit_exceeded_flag, quasi_static} = '0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    yaw_rate = 16'h0000;
    seed = 32'h6bca_3be8;
    failures = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    cyc_n(3);
    chk("init_word", health_word, 16'h0900);
    chk("mag_ref", mag_ref_on, 1'b1);
    rd(ADR_CTRL, d);
    chk("ctrl_rst", d, 32'h0000_000e);
    rd(ADR_THRESH, d);
    chk("thresh_rst", d, 32'h0000_0280);
    rd(8'h14, d);
    chk("unmapped", d, 32'h0000_0000);
    wait_for(update_tick, 1'b1, 100, n);
    wait_for(update_tick, 1'b1, 100, n);
    chk("tick_gap", n, TC);
    wait_for(pkt_stb, 1'b1, 100, n);
    chk("default_kind", 32'(pkt_kind), 32'(PKT_ANGLE));
    wait_for(high_gain, 1'b0, 400, n);
    cyc_n(3);
    chk("run_word", health_word, 16'h0000);
    for (int s = 0; s < 7; s++) begin
      wr(ADR_CTRL, 32'h0000_000e | (s << 8) | ((s & 1) << 12));
      wait_for(pkt_stb, 1'b1, 2000, n);
      wait_for(pkt_stb, 1'b1, 2000, n);
      chk("pkt_gap", n, TC * 100 / rate[s]);
      chk("pkt_kind", 32'(pkt_kind), s & 1);
    end
    wr(ADR_CTRL, 32'h0000_070e);
    cyc_n(5);
    p0 = pkt_cnt;
    cyc_n(300);
    chk("no_periodic", pkt_cnt - p0, 0);
    // fetch then measurement request on consecutive edges
    @(posedge sys_clk);
    addr <= ADR_CMD;
    wdata <= 32'h0000_0001;
    wstrb <= 1'b1;
    @(posedge sys_clk);
    wdata <= 32'h0000_0002;
    @(posedge sys_clk);
    wstrb <= 1'b0;
    cyc_n(10);
    chk("req_pkts", pkt_cnt - p0, 2);
    chk("req_order", kind_hist, {2'(PKT_DIAG), 2'(PKT_ANGLE)});
    for (int j = 0; j < 4; j++) begin
      v = rnd();
      en = v[11:8];
      wr(ADR_CTRL, 32'h0000_0700 | en);
      for (int i = 0; i < 60; i++) begin
        v = rnd();
        @(posedge sys_clk);
        {rate_rate_limit_exceeded_flag, link_absent, hw_alert_in, sw_fault, link_fault,
         hw_fault, fatal_in} <= v[6:0];
        cyc_n(1);
        chk("word", health_word, exp_hw(v[6:0], en));
      end
    end
    @(posedge sys_clk);
    {rate_rate_limit_exceeded_flag, link_absent, hw_alert_in, sw_fault, link_fault,
     hw_fault, fatal_in} <= 7'h00;
    wr(ADR_MAGOFF, 32'h0000_0003);
    cyc_n(2);
    chk("mag_off", mag_ref_on, 1'b0);
    wait_for(mag_ref_on, 1'b1, 200, n);
    chk("mag_span", n + 2 > 2 * TC && n + 2 <= 3 * TC, 1'b1);
    wr(ADR_CTRL, 32'h0000_070e);
    @(posedge sys_clk);
    yaw_rate <= 16'h0200;
    hits = 0;
    for (int i = 0; i < 1000; i++) begin
      cyc_n(1);
      hits += (accel_gain_low === 1'b1);
    end
    chk("below_default", hits, 0);
    yaw_rate <= 16'h0300;
    wait_for(accel_gain_low, 1'b1, 1000, n);
    cyc_n(3);
    chk("turn_hidden", health_word[11], 1'b0);
    wr(ADR_CTRL, 32'h0000_071e);
    cyc_n(3);
    chk("turn_shown", health_word[11], 1'b1);
    wr(ADR_THRESH, 32'h0000_0040);
    rd(ADR_THRESH, d);
    chk("thresh_rw", d, 32'h0000_0040);
    // turn kept short, as the host is expected to do
    yaw_rate <= 16'h0000;
    wait_for(accel_gain_low, 1'b0, 1500, n);
    cyc_n(3);
    chk("turn_end", health_word[11], 1'b0);
    wr(ADR_CTRL, 32'h0000_072e);
    @(posedge sys_clk);
    rate_rate_limit_exceeded_flag <= 1'b1;
    cyc_n(50);
    chk("ovr_fatal", health_word, 16'h1101);
    rd(ADR_STATUS, d);
    chk("status", d, 32'h0003_1101);
    rate_rate_limit_exceeded_flag <= 1'b0;
    quasi_static <= 1'b1;
    wait_for(high_gain, 1'b1, 50, n);
    cyc_n(3);
    chk("restart", health_word, 16'h0900);
    wait_for(high_gain, 1'b0, 400, n);
    chk("init_len", n + 3 > IT * TC && n + 3 <= (IT + 1) * TC, 1'b1);
    chk("host_bad", bad_cnt, 0);
    end_sim();
  end
endmodule

// ===== btsw_host_model.sv
// host side receiver of measurement and diagnostic packets for the health word block
`timescale 1ns/1ps
module btsw_host_model (
  input  wire logic        sys_clk,
  input  wire logic        pkt_stb,
  input  wire logic [1:0]  pkt_kind,
  input  wire logic [15:0] pkt_health,
  input  wire logic [15:0] health_word,
  output int               pkt_cnt,
  output int               bad_cnt,
  output logic [3:0]       kind_hist
);
  initial begin
    pkt_cnt = 0;
    bad_cnt = 0;
    kind_hist = 4'h0;
  end

  // =========================================================================
  // packet capture: the host only sees what the strobe qualifies
  always @(posedge sys_clk) begin
    if (pkt_stb === 1'b1) begin
      pkt_cnt <= pkt_cnt + 1;
      kind_hist <= {kind_hist[1:0], pkt_kind};
      if (pkt_health !== health_word)
        bad_cnt <= bad_cnt + 1;
      if (pkt_health[7:4] !== 4'h0 || pkt_health[15:13] !== 3'h0)
        bad_cnt <= bad_cnt + 1;
    end
  end
endmodule

// ===== btsw_pkg.sv
// constants, field positions and types shared by the health word block
package btsw_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int UPDATE_HZ   = 100;
  localparam int TICK_CYCLES = CLK_HZ / UPDATE_HZ;
  localparam int INIT_SEC    = 60;
  localparam int INIT_TICKS  = INIT_SEC * UPDATE_HZ;

  // ==========================================================================
  // register port and offsets
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_THRESH = 8'h04;
  localparam logic [7:0] ADR_MAGOFF = 8'h08;
  localparam logic [7:0] ADR_CMD    = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;

  // ==========================================================================
  // control register fields
  localparam int EN_HW        = 0;
  localparam int EN_LINK      = 1;
  localparam int EN_ALGO      = 2;
  localparam int EN_SENS      = 3;
  localparam int CT_TURN      = 4;
  localparam int CT_RESTART   = 5;
  localparam int CT_RATE_LSB  = 8;
  localparam int CT_RATE_W    = 3;
  localparam int CT_KIND      = 12;
  localparam int CMD_DIAG     = 0;
  localparam int CMD_MEAS     = 1;
  localparam logic [31:0] CTRL_MASK = 32'h0000_173f;
  localparam logic [31:0] CTRL_RST  = 32'h0000_000e;
  localparam logic [2:0]  RATE_REQ  = 3'h7;

  // threshold in 1/64 deg/s units, default 10.0 deg/s
  localparam logic [15:0] THRESH_RST = 16'h0280;
  localparam int          LPF_SHIFT  = 3;

  // ==========================================================================
  // health word bit positions
  localparam int HB_FATAL = 0;
  localparam int HB_HWF   = 1;
  localparam int HB_LNKF  = 2;
  localparam int HB_SWF   = 3;
  localparam int HB_ANY   = 8;
  localparam int HB_HWA   = 9;
  localparam int HB_LNKA  = 10;
  localparam int HB_ALGA  = 11;
  localparam int HB_OVRA  = 12;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    PKT_ANGLE,
    PKT_SCALED,
    PKT_DIAG
  } btsw_pkt_e;

  typedef enum logic [1:0] {
    PH_INIT,
    PH_RUN,
    PH_HOLD
  } btsw_phase_e;

  // ==========================================================================
  // helpers
  function automatic logic [5:0] btsw_rate_div(input logic [2:0] sel);
    case (sel)
      3'h0:    btsw_rate_div = 6'h01;
      3'h1:    btsw_rate_div = 6'h02;
      3'h2:    btsw_rate_div = 6'h04;
      3'h3:    btsw_rate_div = 6'h05;
      3'h4:    btsw_rate_div = 6'h0a;
      3'h5:    btsw_rate_div = 6'h14;
      default: btsw_rate_div = 6'h32;
    endcase
  endfunction

  function automatic logic [15:0] btsw_abs16(input logic signed [15:0] v);
    btsw_abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

endpackage

// ===== btsw_tick_div.sv
// fixed-rate update enable divider
`timescale 1ns/1ps
module btsw_tick_div #(
  parameter int CYCLES = btsw_pkg::TICK_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  output logic      tick
);
  import btsw_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } btsw_div_s;

  btsw_div_s s;
  btsw_div_s next_s;

  // ==========================================================================
  // count one update period
  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (s.cnt == 32'(CYCLES - 1)) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  AST_TICK_PERIOD: assert property (@(posedge sys_clk) disable iff (!nrst)
    tick |-> s.cnt == '0)
    else $error("update tick out of period");

endmodule

// ===== btsw_turn_detect.sv
// low-passed yaw rate compared to the turn threshold
`timescale 1ns/1ps
module btsw_turn_detect (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        tick,
  input  wire logic [15:0] yaw_rate,
  input  wire logic [15:0] thresh,
  output logic             active
);
  import btsw_pkg::*;

  typedef struct packed {
    logic [15:0] lpf;
    logic        active;
  } btsw_turn_s;

  btsw_turn_s s;
  btsw_turn_s next_s;

  // ==========================================================================
  // first-order filter, stepped once per update
  always_comb begin
    logic signed [16:0] diff;
    logic signed [16:0] sum;
    diff   = '0;
    sum    = '0;
    next_s = s;
    if (tick) begin
      diff = $signed({1'b0, btsw_abs16(yaw_rate)}) - $signed({1'b0, s.lpf});
      sum  = $signed({1'b0, s.lpf}) + (diff >>> LPF_SHIFT);
      next_s.lpf    = sum[15:0];
      next_s.active = sum[15:0] > thresh;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign active = s.active;

  AST_TURN_ON_TICK: assert property (@(posedge sys_clk) disable iff (!nrst)
    !tick |=> $stable(active))
    else $error("turn flag changed outside an update");

endmodule
